/* dv/hbp_host_model.sv */
/* Host side partner: grants the bus and ends every bus cycle.
   Assumes the bench resolves the data pins from the enables. */
`default_nettype none
module hbp_host_model
(
    // Clock and bench control
    input  wire logic        i_ref_clk,
    input  wire logic        i_hold_off,
    // Port pins watched
    input  wire logic        i_bus_request,
    input  wire logic        i_strobe_n,
    input  wire logic        i_second_phase,
    input  wire logic        i_master_read,
    input  wire logic [29:0] i_addr,
    // Pins driven
    output logic             o_bus_grant,
    output logic             o_cycle_done_n,
    output logic [31:0]      o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Memory contents seen by master reads
    function automatic logic [31:0] rd_word(input logic [29:0] a);
        rd_word = 32'hC3A50000 ^ {2'h0, a};
    endfunction : rd_word

    ////////////////////////////////////////
    // Grant follows request after a random pause, withdrawn when held off
    initial
    begin
        o_bus_grant = 1'b0;
        o_cycle_done_n = 1'b1;
        o_data = 32'h0;
        forever
        begin
            @(posedge i_ref_clk) #1;
            if (!i_bus_request || i_hold_off) o_bus_grant = 1'b0;
            else if ($urandom_range(1)) o_bus_grant = 1'b1;
        end
    end

    // Every strobe ends after some wait states; stale data is inverted
    initial
    begin
        forever
        begin
            @(negedge i_ref_clk);
            if (!i_strobe_n)
            begin
                repeat (3 + $urandom_range(3)) @(posedge i_ref_clk);
                #1 o_cycle_done_n = 1'b0;
                o_data = i_master_read ? rd_word(i_addr) : ~o_data;
                do @(negedge i_ref_clk); while (!i_second_phase);
                @(posedge i_ref_clk) #1 o_cycle_done_n = 1'b1;
                o_data = ~o_data;
            end
        end
    end
endmodule : hbp_host_model
`default_nettype wire

/* dv/hbp_port_properties.sv */
/* Pin-level checker for the host bus port.
   Bound to hbp_port from the bench; sees only the port's own pins. */
`default_nettype none
module hbp_port_properties
    import hbp_pkg::*;
(
    // Clock, reset and phases
    input wire logic       i_ref_clk,
    input wire logic       i_nrst,
    input wire logic       o_first_phase,
    input wire logic       o_second_phase,
    input wire logic       o_processor_reset_out,
    // Arbitration and master cycle
    input wire logic       o_bus_request,
    input wire logic       i_bus_grant,
    input wire logic       o_addr_oe,
    input wire logic       o_addr_strobe_n,
    input wire logic       o_data_or_control,
    input wire logic       i_cycle_done,
    input wire logic       o_rd_valid,
    // Data and slave side
    input wire logic [3:0] i_byte_lane_selects,
    input wire logic [31:0] i_data,
    input wire logic [31:0] o_data,
    input wire logic       o_data_oe,
    input wire logic       o_reg_valid,
    input wire hbp_slave_t o_reg_access
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    // Offset implied by the lowest enabled lane
    function automatic logic [1:0] lane_addr(input logic [3:0] s);
        lane_addr = !s[0] ? 2'h0 : !s[1] ? 2'h1 : !s[2] ? 2'h2 : 2'h3;
    endfunction : lane_addr

    // Cycles the processor has been held in reset; the count keeps the wake-up honest
    logic [7:0] rst_cnt_q, rst_cnt_d;
    always_comb rst_cnt_d = o_processor_reset_out ? rst_cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge i_ref_clk or negedge i_nrst)
        if (!i_nrst) rst_cnt_q <= 8'h00;
        else rst_cnt_q <= rst_cnt_d;

    ////////////////////////////////////////
    AST_PHASE: assert property (o_first_phase |-> !o_second_phase ##1
        (o_second_phase && !o_first_phase)) else $error("phases do not alternate");
    AST_QUIET: assert property (!o_bus_request |-> !o_addr_oe && o_addr_strobe_n)
        else $error("bus driven outside master role");
    AST_GRANT: assert property ($rose(o_addr_oe) |-> o_bus_request && $past(i_bus_grant))
        else $error("master role without grant");
    AST_DROP: assert property (o_addr_oe && !i_bus_grant |-> ##[0:2] !o_addr_oe)
        else $error("master role kept after grant loss");
    AST_REQ: assert property (o_addr_oe |-> o_bus_request && o_data_or_control)
        else $error("request or data level lost in master role");
    AST_DUP: assert property (o_data_oe && !o_addr_oe |-> o_data == {4{o_data[7:0]}})
        else $error("read byte not on all lanes");
    AST_WR_ADDR: assert property (o_reg_valid && o_reg_access.is_write |->
        o_reg_access.low_addr == lane_addr($past(i_byte_lane_selects)))
        else $error("write offset wrong");
    AST_WR_LANE: assert property (o_reg_valid && o_reg_access.is_write |->
        o_reg_access.data == (o_reg_access.low_addr[0] ? $past(i_data[15:8]) : $past(i_data[7:0])))
        else $error("write byte from wrong lane");
    AST_PRST: assert property ($fell(o_processor_reset_out) |->
        rst_cnt_q >= 8'h3A && rst_cnt_q <= 8'h42) else $error("processor reset length wrong");
    AST_DONE: assert property (o_rd_valid |-> !$past(i_cycle_done))
        else $error("read result without cycle end");
endmodule : hbp_port_properties
`default_nettype wire

/* dv/tb.sv */
/* Bench for the host bus port: slave accesses, buffered master cycles, grant loss.
   Assumes the host model on the far side and the checker bound at the foot. */
`default_nettype none
module tb
    import hbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DEPTH = 8;
    localparam logic [3:0] PAT [4] = '{4'h0, 4'h1, 4'h3, 4'h7};
    localparam logic [3:0] MSK [4] = '{4'h1, 4'h3, 4'h7, 4'h7};
    // Pins named as the ports so that they join by name
    logic        i_ref_clk, i_nrst, i_bus_grant, i_cycle_done, hold;
    logic [1:0]  seen;
    logic        i_addr_strobe_n, i_mem_io, i_data_or_control, i_write_read;
    logic        i_next_address_request, i_reg_select, i_xfer_valid, o_xfer_ready;
    logic        o_first_phase, o_second_phase, o_processor_reset_out, o_bus_request;
    logic        o_addr_oe, o_addr_strobe_n, o_mem_io, o_data_or_control, o_write_read;
    logic        o_data_oe, o_reg_valid, o_rd_valid;
    logic [29:0] i_addr, o_addr;
    logic [3:0]  i_byte_lane_selects, o_byte_lane_selects;
    logic [7:0]  i_reg_rdata, i_int_vector;
    logic [31:0] hd, md, o_data, o_rd_data;
    wire logic [31:0] i_data;
    hbp_slave_t  o_reg_access;
    hbp_xfer_t   i_xfer;
    hbp_slave_t  wq[$];
    logic [31:0] dq[$];
    logic [35:0] sq[$];
    logic [63:0] rq[$];
    int          num_errors, num_checks, n;

    hbp_port #(.DEPTH(DEPTH)) dut (.*);
    hbp_host_model mdl (.i_ref_clk(i_ref_clk), .i_hold_off(hold), .i_bus_request(o_bus_request),
        .i_strobe_n(o_addr_strobe_n & i_addr_strobe_n), .i_second_phase(o_second_phase),
        .i_master_read(o_addr_oe & ~o_write_read), .i_addr(o_addr),
        .o_bus_grant(i_bus_grant), .o_cycle_done_n(i_cycle_done), .o_data(md));
    // One party on the data pins at a time
    assign i_data = o_data_oe ? o_data : (o_addr_oe ? md : hd);

    ////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        #50us;
        num_errors++;
        finish_test();
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Host cycle: strobe for one state, held until the cycle is ended
    task automatic slave(input logic w, input logic [1:0] k, input logic reg_c);
        @(posedge i_ref_clk) #1;
        i_addr = 30'($urandom);
        i_byte_lane_selects = (4'($urandom) & ~MSK[k]) | PAT[k];
        {i_addr_strobe_n, i_mem_io, i_data_or_control, i_write_read} = {3'h0, reg_c, w};
        i_reg_select = reg_c;
        hd = $urandom;
        i_reg_rdata = 8'($urandom);
        i_int_vector = 8'($urandom);
        if (w) wq.push_back({1'b1, i_addr, k, k[0] ? hd[15:8] : hd[7:0]});
        else dq.push_back({4{reg_c ? i_reg_rdata : i_int_vector}});
        do @(negedge i_ref_clk); while (!o_second_phase);
        @(posedge i_ref_clk) #1 i_addr_strobe_n = 1'b1;
        do @(negedge i_ref_clk); while (i_cycle_done !== 1'b0 || !o_second_phase);
        @(posedge i_ref_clk) #1 i_reg_select = 1'b0;
        hd = ~hd;
    endtask : slave

    // Queue one transfer and note its cycle and read result
    task automatic push(input int i);
        hbp_xfer_t   x;
        logic [3:0]  s;
        logic [29:0] a;
        logic [31:0] m;
        x = '0;
        {x.is_mem, x.is_write} = {i[0], i[1]};
        x.width = hbp_width_t'(i % 3);
        x.word_addr = 30'($urandom);
        x.data = $urandom;
        if (x.width != HBP_W32) x.low_addr = 2'($urandom_range(x.width == HBP_W8 ? 3 : 2));
        s = ~(4'(x.width == HBP_W8 ? 1 : x.width == HBP_W16 ? 3 : 15) << x.low_addr);
        a = x.is_mem ? x.word_addr : x.word_addr & IO_ADDR_MASK;
        for (int b = 0; b < 4; b++) m[8*b+:8] = {8{~s[b]}};
        sq.push_back({x.is_mem, x.is_write, s, a});
        if (!x.is_write) rq.push_back({m, mdl.rd_word(a) & m});
        i_xfer = x;
        i_xfer_valid = 1'b1;
    endtask : push

    // Results take the oldest note of their kind; read mid-cycle, once settled
    always @(negedge i_ref_clk)
    begin
        logic [63:0] e;
        if (o_reg_valid === 1'b1 && o_reg_access.is_write === 1'b1)
            chk(64'(o_reg_access), 64'(wq.pop_front()));
        if (o_data_oe === 1'b1 && !o_addr_oe && !seen[0])
            chk(64'(o_data), 64'(dq.pop_front()));
        if (o_addr_strobe_n === 1'b0 && o_addr_oe && !seen[1])
            chk({o_mem_io, o_write_read, o_byte_lane_selects, o_addr}, sq.pop_front());
        seen = {o_addr_strobe_n === 1'b0, o_data_oe && !o_addr_oe};
        if (o_rd_valid === 1'b1)
        begin
            e = rq.pop_front();
            chk({e[63:32], o_rd_data & e[63:32]}, e);
        end
    end

    ////////////////////////////////////////
    initial
    begin
        {i_nrst, i_mem_io, i_data_or_control, i_write_read, i_reg_select} = 5'h0;
        {i_xfer_valid, seen, i_addr, i_reg_rdata, i_int_vector, hd} = 81'h0;
        {i_addr_strobe_n, i_next_address_request, hold} = 3'h7;
        i_byte_lane_selects = 4'h7;
        i_xfer = '0;
        n = $urandom(96);
        repeat (15) @(posedge i_ref_clk);
        #1 i_nrst = 1'b1;
        for (n = 0; n < 300 && o_processor_reset_out !== 1'b0; n++) @(posedge i_ref_clk) #1;
        chk(64'(o_processor_reset_out), 64'h0);
        // Register writes at every offset, reads, then an interrupt vector
        for (int i = 0; i < 8; i++) slave(1'b1, 2'(i), 1'b1);
        repeat (2) slave(1'b0, 2'h0, 1'b1);
        slave(1'b0, 2'h0, 1'b0);
        // Fill the buffer while the host withholds the bus
        for (n = 0; n < 12 && o_xfer_ready === 1'b1; n++)
        begin
            push(n);
            @(posedge i_ref_clk) #1;
        end
        i_xfer_valid = 1'b0;
        chk(64'(n), 64'(DEPTH));
        hold = 1'b0;
        for (n = 0; n < 3000 && (sq.size() || rq.size()); n++) @(posedge i_ref_clk);
        // Withdraw the grant in mid cycle
        @(posedge i_ref_clk) #1 push(2);
        @(posedge i_ref_clk) #1 i_xfer_valid = 1'b0;
        for (n = 0; n < 300 && o_addr_strobe_n !== 1'b0; n++) @(posedge i_ref_clk) #1;
        chk(64'(o_addr_strobe_n), 64'h0);
        hold = 1'b1;
        repeat (4) @(posedge i_ref_clk);
        chk(64'(o_addr_oe), 64'h0);
        chk(64'(wq.size() + dq.size() + sq.size() + rq.size()), 64'h0);
        finish_test();
    end
endmodule : tb

bind hbp_port hbp_port_properties props (.*);
`default_nettype wire

/* hw/hbp_fifo.sv */
/*
 * Small synchronous FIFO held in flip-flops, valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`default_nettype none

module hbp_fifo
    import hbp_pkg::*;
#(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    ////////////////////////////////////////////////////////////////////
    // Pointer and count update; full and empty come from the count
    always_comb
    begin
        push = i_in_valid && o_in_ready;
        pop  = o_out_valid && i_out_ready;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];

    // Registers
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage carries no reset; contents are only read when counted valid
    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= i_in_data;
        end
    end

endmodule : hbp_fifo

`default_nettype wire

/* hw/hbp_pkg.sv */
/*
 * Package for the host bus port: transfer width codes, field positions,
 * reset values and timing counts shared by the port and its FIFO.
 * Assumes a single 250 MHz clock that plays the double-rate clock.
 */
`default_nettype none

package hbp_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS     = 4;
    localparam int unsigned PROC_RST_PERIODS  = 62;   // Double-rate periods
    localparam int unsigned PROC_RST_CYCLES   = PROC_RST_PERIODS;
    localparam int unsigned MIN_RST_PERIODS   = 15;

    // Widths and values after reset
    localparam int unsigned ADDR_W            = 30;   // Word address lines
    localparam int unsigned DATA_W            = 32;
    localparam logic [3:0]  LANES_IDLE        = 4'hF;
    localparam logic [3:0]  LANES_ALL         = 4'h0;
    localparam logic [29:0] IO_ADDR_MASK      = 30'h00003FFF; // 64K I/O bytes
    localparam int unsigned FIFO_DEPTH        = 8;

    // Transfer width codes
    typedef enum logic [1:0] {
        HBP_W8  = 2'h0,
        HBP_W16 = 2'h1,
        HBP_W32 = 2'h2
    } hbp_width_t;

    // One master transfer request as handed in by the channel logic
    typedef struct packed {
        logic        is_mem;     // Memory (1) or I/O (0) space
        logic        is_write;
        hbp_width_t  width;
        logic [1:0]  low_addr;   // Byte offset inside the double word
        logic [29:0] word_addr;
        logic [31:0] data;
    } hbp_xfer_t;

    // Slave register access presented to the internal registers
    typedef struct packed {
        logic        is_write;
        logic [29:0] word_addr;
        logic [1:0]  low_addr;
        logic [7:0]  data;
    } hbp_slave_t;

endpackage : hbp_pkg

`default_nettype wire

/* hw/hbp_port.sv */
/*
 * Host local-bus port: slave register access and master transfer engine.
 * Assumes i_ref_clk is the double-rate clock, all pins synchronous to it,
 * and that the bench resolves three-state pins from the enables.
 */
`default_nettype none

module hbp_port
    import hbp_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_nrst,
    // Phase outputs and processor reset
    output logic                   o_first_phase,
    output logic                   o_second_phase,
    output logic                   o_processor_reset_out,
    // Arbitration
    output logic                   o_bus_request,
    input  wire logic              i_bus_grant,
    // Address and byte lane pins
    input  wire logic [29:0]       i_addr,
    output logic [29:0]            o_addr,
    output logic                   o_addr_oe,
    input  wire logic [3:0]        i_byte_lane_selects,
    output logic [3:0]             o_byte_lane_selects,
    // Cycle definition and status
    input  wire logic              i_addr_strobe_n,
    output logic                   o_addr_strobe_n,
    input  wire logic              i_mem_io,
    input  wire logic              i_data_or_control,
    input  wire logic              i_write_read,
    output logic                   o_mem_io,
    output logic                   o_data_or_control,
    output logic                   o_write_read,
    input  wire logic              i_cycle_done,
    input  wire logic              i_next_address_request,
    // Data pins
    input  wire logic [31:0]       i_data,
    output logic [31:0]            o_data,
    output logic                   o_data_oe,
    // Slave register side
    input  wire logic              i_reg_select,
    output logic                   o_reg_valid,
    output hbp_slave_t             o_reg_access,
    input  wire logic [7:0]        i_reg_rdata,
    input  wire logic [7:0]        i_int_vector,
    // Master transfer requests and read results
    input  wire logic              i_xfer_valid,
    output logic                   o_xfer_ready,
    input  wire hbp_xfer_t         i_xfer,
    output logic                   o_rd_valid,
    output logic [31:0]            o_rd_data
);

    ////////////////////////////////////////////////////////////////////
    // Transfer FIFO: back-pressure reaches the channel logic via o_xfer_ready
    localparam int unsigned XW = $bits(hbp_xfer_t);

    logic             q_valid;
    logic             q_ready;
    logic [XW-1:0]    q_bits;
    hbp_xfer_t        q_xfer;

    hbp_fifo #(
        .WIDTH (XW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_in_valid  (i_xfer_valid),
        .o_in_ready  (o_xfer_ready),
        .i_in_data   (i_xfer),
        .o_out_valid (q_valid),
        .i_out_ready (q_ready),
        .o_out_data  (q_bits)
    );

    assign q_xfer = hbp_xfer_t'(q_bits);

    ////////////////////////////////////////////////////////////////////
    // Phase divider and processor reset timer
    logic       phase_q, phase_d;              // 1 = second phase
    logic [6:0] rst_cnt_q, rst_cnt_d;
    logic       prst_q, prst_d;

    always_comb
    begin
        phase_d   = ~phase_q;
        rst_cnt_d = rst_cnt_q;
        prst_d    = prst_q;
        if (rst_cnt_q != '0)
        begin
            rst_cnt_d = rst_cnt_q - 1'b1;
        end
        // Release only entering a second phase, so the processor's first
        // internal edge lands on our first phase
        if (prst_q && rst_cnt_q <= 7'h01 && !phase_q)
        begin
            prst_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            phase_q   <= 1'b0;
            rst_cnt_q <= 7'(PROC_RST_CYCLES);
            prst_q    <= 1'b1;
        end
        else
        begin
            phase_q   <= phase_d;
            rst_cnt_q <= rst_cnt_d;
            prst_q    <= prst_d;
        end
    end

    assign o_first_phase         = ~phase_q;
    assign o_second_phase        = phase_q;
    assign o_processor_reset_out = prst_q;

    ////////////////////////////////////////////////////////////////////
    // Role state machine
    typedef enum logic [2:0] {
        ST_SLAVE,
        ST_REQ,
        ST_ADDR,
        ST_WAIT,
        ST_DONE
    } hbp_state_t;

    hbp_state_t  st_q, st_d;
    hbp_xfer_t   cur_q, cur_d;
    logic        piped_q, piped_d;   // Next address requested while more work is queued
    logic [31:0] rdat_q, rdat_d;
    logic        rval_q, rval_d;
    logic        sp2;                // Second-phase sample point

    assign sp2 = phase_q;

    // Byte-lane select encoding from offset and width
    function automatic logic [3:0] lanes_of(input logic [1:0] off, input hbp_width_t w);
        logic [3:0] m;
        m = 4'h1;
        case (w)
            HBP_W16: m = 4'h3;
            HBP_W32: m = 4'hF;
            default: m = 4'h1;
        endcase
        lanes_of = ~(4'((m << off) & 4'hF));
    endfunction : lanes_of

    always_comb
    begin
        st_d    = st_q;
        cur_d   = cur_q;
        piped_d = piped_q;
        rdat_d  = rdat_q;
        rval_d  = 1'b0;
        q_ready = 1'b0;
        case (st_q)
            ST_SLAVE:
            begin
                if (q_valid && !prst_q)
                begin
                    st_d = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (sp2 && i_bus_grant)
                begin
                    q_ready = 1'b1;
                    cur_d   = q_xfer;
                    st_d    = ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                if (sp2)
                begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // Pipelined address only when more work is queued
                if (sp2 && !i_next_address_request && q_valid && !piped_q)
                begin
                    piped_d = 1'b1;
                end
                if (sp2 && !i_cycle_done)
                begin
                    // Read data latched on the following first phase
                    rdat_d  = i_data;
                    rval_d  = !cur_q.is_write;
                    piped_d = 1'b0;
                    st_d    = ST_DONE;
                end
            end
            ST_DONE:
            begin
                if (q_valid && i_bus_grant)
                begin
                    q_ready = 1'b1;
                    cur_d   = q_xfer;
                    st_d    = piped_q ? ST_WAIT : ST_ADDR;
                end
                else
                begin
                    st_d = ST_SLAVE;
                end
                piped_d = 1'b0;
            end
            default:
            begin
                st_d = ST_SLAVE;
            end
        endcase
        // Grant withdrawn: drop the master role at once
        if (st_q != ST_SLAVE && st_q != ST_REQ && !i_bus_grant)
        begin
            st_d    = ST_SLAVE;
            piped_d = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q    <= ST_SLAVE;
            cur_q   <= '0;
            piped_q <= 1'b0;
            rdat_q  <= '0;
            rval_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cur_q   <= cur_d;
            piped_q <= piped_d;
            rdat_q  <= rdat_d;
            rval_q  <= rval_d;
        end
    end

    assign o_rd_valid = rval_q;
    assign o_rd_data  = rdat_q;

    ////////////////////////////////////////////////////////////////////
    // Master pin drive
    logic master;
    logic [29:0] waddr;

    assign master = (st_q == ST_ADDR) || (st_q == ST_WAIT) || (st_q == ST_DONE);
    assign waddr  = cur_q.is_mem ? cur_q.word_addr
                                 : (cur_q.word_addr & IO_ADDR_MASK);

    assign o_bus_request       = (st_q != ST_SLAVE);
    assign o_addr_oe           = master;
    assign o_addr              = master ? waddr : '0;
    assign o_byte_lane_selects = master ? lanes_of(cur_q.low_addr, cur_q.width)
                                        : LANES_IDLE;
    assign o_addr_strobe_n     = !(st_q == ST_ADDR);
    assign o_mem_io            = cur_q.is_mem;
    assign o_data_or_control   = 1'b1;
    assign o_write_read        = cur_q.is_write;

    ////////////////////////////////////////////////////////////////////
    // Slave decode: sample address and write byte in second phase, latch read byte in first phase
    logic        s_act_q, s_act_d;
    logic        s_ack_q, s_ack_d;
    logic        s_rd_q, s_rd_d;
    logic        s_drv_q, s_drv_d;   // Byte register settled, lanes may drive
    hbp_slave_t  s_acc_q, s_acc_d;
    logic [7:0]  s_rbyte_q, s_rbyte_d;
    logic [1:0]  imp_a;
    logic [7:0]  wbyte;
    logic        is_ack;

    // Implied low address and byte lane from the selects
    always_comb
    begin
        if (!i_byte_lane_selects[0])
        begin
            imp_a = 2'h0;
            wbyte = i_data[7:0];
        end
        else if (!i_byte_lane_selects[1])
        begin
            imp_a = 2'h1;
            wbyte = i_data[15:8];
        end
        else if (!i_byte_lane_selects[2])
        begin
            imp_a = 2'h2;
            wbyte = i_data[7:0];
        end
        else
        begin
            imp_a = 2'h3;
            wbyte = i_data[15:8];
        end
    end

    assign is_ack = !i_mem_io && !i_data_or_control && !i_write_read;

    always_comb
    begin
        s_act_d   = 1'b0;
        s_ack_d   = s_ack_q;
        s_rd_d    = s_rd_q;
        s_acc_d   = s_acc_q;
        s_rbyte_d = s_rbyte_q;
        // Cycle end comes first so that a pipelined strobe in the same
        // state still opens the next access
        if (sp2 && !i_cycle_done)
        begin
            s_rd_d  = 1'b0;
            s_ack_d = 1'b0;
        end
        if (st_q == ST_SLAVE && !prst_q && sp2 && !i_addr_strobe_n)
        begin
            if (is_ack)
            begin
                s_ack_d = 1'b1;
            end
            else if (i_reg_select && i_data_or_control)
            begin
                s_act_d          = 1'b1;
                s_rd_d           = !i_write_read;
                s_acc_d.is_write = i_write_read;
                s_acc_d.word_addr = i_addr;
                s_acc_d.low_addr = imp_a;
                s_acc_d.data     = wbyte;
            end
        end
        if (s_act_q && s_rd_q)
        begin
            s_rbyte_d = i_reg_rdata;
        end
        if (s_ack_q && !sp2)
        begin
            s_rbyte_d = i_int_vector;
        end
        if (st_q != ST_SLAVE)
        begin
            s_rd_d  = 1'b0;
            s_ack_d = 1'b0;
        end
        // Lanes turn on only once the byte register holds the answer
        s_drv_d = (s_rd_d || s_ack_d) && (s_rd_q || s_ack_q);
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_act_q   <= 1'b0;
            s_ack_q   <= 1'b0;
            s_rd_q    <= 1'b0;
            s_drv_q   <= 1'b0;
            s_acc_q   <= '0;
            s_rbyte_q <= '0;
        end
        else
        begin
            s_act_q   <= s_act_d;
            s_ack_q   <= s_ack_d;
            s_rd_q    <= s_rd_d;
            s_drv_q   <= s_drv_d;
            s_acc_q   <= s_acc_d;
            s_rbyte_q <= s_rbyte_d;
        end
    end

    assign o_reg_valid  = s_act_q;
    assign o_reg_access = s_acc_q;

    ////////////////////////////////////////////////////////////////////
    // Data bus drive: write data in master role, duplicated byte on reads
    assign o_data_oe = (master && cur_q.is_write) || s_drv_q;
    assign o_data    = master ? cur_q.data : {4{s_rbyte_q}};

endmodule : hbp_port

`default_nettype wire
